// file: rtl/rsscp_pkg.sv
`default_nettype none

package rsscp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_PHASE  = 8'h6a;
  localparam logic [7:0] ADDR_ENABLE = 8'h6b;
  localparam logic [7:0] ADDR_RANGE  = 8'h6c;
  localparam logic [7:0] ADDR_FREQ   = 8'h6d;
  localparam logic [7:0] ADDR_STEPS  = 8'h6e;
  localparam logic [7:0] ADDR_AMPBND = 8'h6f;
  localparam logic [7:0] ADDR_FAULT  = 8'h70;

  // reset values
  localparam logic [7:0] RST_PHASE  = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_RANGE  = 8'h00;
  localparam logic [7:0] RST_FREQ   = 8'h50;
  localparam logic [7:0] RST_STEPS  = 8'h11;
  localparam logic [7:0] RST_AMPBND = 8'h24;

  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_PHASE  = 8'h0f;
  localparam logic [7:0] MASK_ENABLE = 8'h33;
  localparam logic [7:0] MASK_RANGE  = 8'h7f;
  localparam logic [7:0] MASK_AMPBND = 8'h7f;

  // field positions
  localparam int unsigned PH_SEL_LO   = 2;
  localparam int unsigned PH_AUDIO    = 1;
  localparam int unsigned PH_SYNC     = 0;
  localparam int unsigned EN_PREDIV   = 5;
  localparam int unsigned EN_MANUAL   = 4;
  localparam int unsigned EN_RANDOM   = 1;
  localparam int unsigned EN_TRIANGLE = 0;
  localparam int unsigned RG_RDM_LO   = 4;
  localparam int unsigned RG_TRI_LO   = 0;
  localparam int unsigned ST_FALL_LO  = 4;
  localparam int unsigned ST_RISE_LO  = 0;
  localparam int unsigned AB_AMP_LO   = 5;
  localparam int unsigned AB_BND_LO   = 0;
  localparam int unsigned FL_LDC      = 3;
  localparam int unsigned FL_RDC      = 2;
  localparam int unsigned FL_LOC      = 1;
  localparam int unsigned FL_ROC      = 0;

  // ramp reference and internal defaults used outside manual mode
  localparam int unsigned RAMP_REF_HZ  = 61440000;
  localparam logic [7:0]  AUTO_DIVISOR = 8'h50;
  localparam logic [3:0]  AUTO_STEP    = 4'h1;
  localparam logic [1:0]  AUTO_AMP     = 2'h1;
  localparam logic [4:0]  AUTO_BOUND   = 5'h04;

  typedef struct packed {
    logic [1:0] phase_sel;
    logic       audio_sync;
    logic       phase_sync;
    logic       manual;
    logic       pre_div2;
    logic       random_spread_enable;
    logic       triangle_enable;
    logic [2:0] random_spread_range;
    logic [3:0] triangle_ctrl;
    logic [7:0] manual_ramp_divisor;
    logic [3:0] triangle_fall_step;
    logic [3:0] triangle_rise_step;
    logic [1:0] ramp_amplitude_setting;
    logic [4:0] triangle_period_limit;
  } rsscp_ramp_cfg_t;

  typedef struct packed {
    logic left_dc_fault;
    logic right_dc_fault;
    logic left_overcurrent_fault;
    logic right_overcurrent_fault;
  } rsscp_fault_t;

endpackage : rsscp_pkg

`default_nettype wire

// file: rtl/rsscp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE_01: phase bits 3-2 pick phase 0..3
// RULE_02: host sets phase before playing state
// RULE_03: host matches ramp settings across devices
// RULE_04: bit 1 aligns pwm to audio frames
// RULE_05: bit 0 enables ramp phase sync
// RULE_06: bit 4 selects manual spread mode
// RULE_07: bit 5 selects pll clock over two
// RULE_08: bit 1 enables random, range bits 6-4
// RULE_09: bit 0 enables triangle, bits 3-0 control
// RULE_10: manual frequency 61440000 over divisor, reset 0x50
// RULE_11: fall step bits 7-4, reset one
// RULE_12: rise step bits 3-0, reset one
// RULE_13: amplitude bits 6-5, reset 01
// RULE_14: period limit bits 4-0, reset 00100
// RULE_15: dc faults on bits 3 and 2
// RULE_16: overcurrent faults bits 1,0; 7-4 reserved
// RULE_17: non-manual mode uses internal defaults
// RULE_18: fault register ignores writes, reserved zero
module rsscp_ctrl (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output var  logic [7:0]               reg_rdata,
  output var  logic                     reg_rvalid,
  input  wire rsscp_pkg::rsscp_fault_t  fault_pins,
  output var  rsscp_pkg::rsscp_ramp_cfg_t ramp_cfg
);

  logic [7:0] phase_reg;
  logic [7:0] enable_reg;
  logic [7:0] range_reg;
  logic [7:0] freq_reg;
  logic [7:0] steps_reg;
  logic [7:0] ampbnd_reg;

  // three-stage pin synchroniser
  rsscp_pkg::rsscp_fault_t fsync1;
  rsscp_pkg::rsscp_fault_t fsync2;
  rsscp_pkg::rsscp_fault_t fsync3;
  rsscp_pkg::rsscp_fault_t fault_now;

  // address decode
  wire hit_phase  = (reg_addr == rsscp_pkg::ADDR_PHASE);
  wire hit_enable = (reg_addr == rsscp_pkg::ADDR_ENABLE);
  wire hit_range  = (reg_addr == rsscp_pkg::ADDR_RANGE);
  wire hit_freq   = (reg_addr == rsscp_pkg::ADDR_FREQ);
  wire hit_steps  = (reg_addr == rsscp_pkg::ADDR_STEPS);
  wire hit_ampbnd = (reg_addr == rsscp_pkg::ADDR_AMPBND);
  wire hit_fault  = (reg_addr == rsscp_pkg::ADDR_FAULT);

  // writes to the fault offset do nothing
  wire [7:0] fault_word = {4'h0,                                  // RULE_16 RULE_18
                           fault_now.left_dc_fault,               // RULE_15
                           fault_now.right_dc_fault,              // RULE_15
                           fault_now.left_overcurrent_fault,      // RULE_16
                           fault_now.right_overcurrent_fault};    // RULE_16

  wire [7:0] next_rdata =
      hit_phase  ? phase_reg  :
      hit_enable ? enable_reg :
      hit_range  ? range_reg  :
      hit_freq   ? freq_reg   :
      hit_steps  ? steps_reg  :
      hit_ampbnd ? ampbnd_reg :
      hit_fault  ? fault_word : 8'h00;

  wire manual = enable_reg[rsscp_pkg::EN_MANUAL];   // RULE_06

  // effective ramp settings
  rsscp_pkg::rsscp_ramp_cfg_t next_cfg;
  always_comb begin
    next_cfg.phase_sel  = phase_reg[rsscp_pkg::PH_SEL_LO +: 2];   // RULE_01
    next_cfg.audio_sync = phase_reg[rsscp_pkg::PH_AUDIO];         // RULE_04
    next_cfg.phase_sync = phase_reg[rsscp_pkg::PH_SYNC];          // RULE_05
    next_cfg.manual     = manual;                                 // RULE_06
    next_cfg.random_spread_enable = enable_reg[rsscp_pkg::EN_RANDOM];   // RULE_08
    next_cfg.triangle_enable      = enable_reg[rsscp_pkg::EN_TRIANGLE]; // RULE_09
    next_cfg.random_spread_range  = range_reg[rsscp_pkg::RG_RDM_LO +: 3]; // RULE_08
    next_cfg.triangle_ctrl        = range_reg[rsscp_pkg::RG_TRI_LO +: 4]; // RULE_09
    if (manual) begin
      next_cfg.pre_div2               = enable_reg[rsscp_pkg::EN_PREDIV];     // RULE_07
      next_cfg.manual_ramp_divisor    = freq_reg;                             // RULE_10
      next_cfg.triangle_fall_step     = steps_reg[rsscp_pkg::ST_FALL_LO +: 4]; // RULE_11
      next_cfg.triangle_rise_step     = steps_reg[rsscp_pkg::ST_RISE_LO +: 4]; // RULE_12
      next_cfg.ramp_amplitude_setting = ampbnd_reg[rsscp_pkg::AB_AMP_LO +: 2]; // RULE_13
      next_cfg.triangle_period_limit  = ampbnd_reg[rsscp_pkg::AB_BND_LO +: 5]; // RULE_14
    end else begin
      next_cfg.pre_div2               = 1'b0;                        // RULE_17
      next_cfg.manual_ramp_divisor    = rsscp_pkg::AUTO_DIVISOR;     // RULE_17
      next_cfg.triangle_fall_step     = rsscp_pkg::AUTO_STEP;        // RULE_17
      next_cfg.triangle_rise_step     = rsscp_pkg::AUTO_STEP;        // RULE_17
      next_cfg.ramp_amplitude_setting = rsscp_pkg::AUTO_AMP;         // RULE_17
      next_cfg.triangle_period_limit  = rsscp_pkg::AUTO_BOUND;       // RULE_17
    end
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_reg  <= rsscp_pkg::RST_PHASE;
      enable_reg <= rsscp_pkg::RST_ENABLE;
      range_reg  <= rsscp_pkg::RST_RANGE;
      freq_reg   <= rsscp_pkg::RST_FREQ;     // RULE_10
      steps_reg  <= rsscp_pkg::RST_STEPS;    // RULE_11 RULE_12
      ampbnd_reg <= rsscp_pkg::RST_AMPBND;   // RULE_13 RULE_14
    end else if (reg_wr) begin
      if (hit_phase)  phase_reg  <= reg_wdata & rsscp_pkg::MASK_PHASE;
      if (hit_enable) enable_reg <= reg_wdata & rsscp_pkg::MASK_ENABLE;
      if (hit_range)  range_reg  <= reg_wdata & rsscp_pkg::MASK_RANGE;
      if (hit_freq)   freq_reg   <= reg_wdata;
      if (hit_steps)  steps_reg  <= reg_wdata;
      if (hit_ampbnd) ampbnd_reg <= reg_wdata & rsscp_pkg::MASK_AMPBND;
    end
  end

  // fault synchroniser, change taken when stages two and three agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      fsync1    <= '0;
      fsync2    <= '0;
      fsync3    <= '0;
      fault_now <= '0;
    end else begin
      fsync1 <= fault_pins;
      fsync2 <= fsync1;
      fsync3 <= fsync2;
      if (fsync2 == fsync3) fault_now <= fsync3;
    end
  end

  // read data and config outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
      ramp_cfg   <= '0;
    end else begin
      reg_rdata  <= reg_rd ? next_rdata : 8'h00;
      reg_rvalid <= reg_rd;
      ramp_cfg   <= next_cfg;
    end
  end

  // checks
  property p_fault_reserved;
    @(posedge mclk) disable iff (srst)
      reg_rvalid |-> (reg_rdata[7:4] == 4'h0) || !$past(hit_fault);
  endproperty
  a_fault_reserved: assert property (p_fault_reserved) // RULE_16
    else $error("fault reserved bits not zero");

  property p_fault_ro;
    @(posedge mclk) disable iff (srst)
      (reg_wr && hit_fault) |=> $stable(phase_reg) && $stable(enable_reg);
  endproperty
  a_fault_ro: assert property (p_fault_ro) // RULE_18
    else $error("fault write disturbed registers");

  property p_auto_default;
    @(posedge mclk) disable iff (srst)
      (!srst && !manual) |=> (ramp_cfg.manual_ramp_divisor == rsscp_pkg::AUTO_DIVISOR)
                  && !ramp_cfg.pre_div2;
  endproperty
  a_auto_default: assert property (p_auto_default) // RULE_17
    else $error("manual fields used outside manual mode");

  property p_manual_div;
    @(posedge mclk) disable iff (srst)
      manual |=> ramp_cfg.manual_ramp_divisor == $past(freq_reg);
  endproperty
  a_manual_div: assert property (p_manual_div) // RULE_10
    else $error("manual divisor not applied");

  property p_phase_sel;
    @(posedge mclk) disable iff (srst)
      (reg_wr && hit_phase) |=> ##1 ramp_cfg.phase_sel == $past(reg_wdata[3:2], 2);
  endproperty
  a_phase_sel: assert property (p_phase_sel) // RULE_01
    else $error("phase select not applied");

  property p_sync_bits;
    @(posedge mclk) disable iff (srst)
      (reg_wr && hit_phase) |=> ##1
        (ramp_cfg.audio_sync == $past(reg_wdata[1], 2)) &&
        (ramp_cfg.phase_sync == $past(reg_wdata[0], 2));
  endproperty
  a_sync_bits: assert property (p_sync_bits) // RULE_04 RULE_05
    else $error("sync bits not applied");

  property p_spread_en;
    @(posedge mclk) disable iff (srst)
      (reg_wr && hit_enable) |=> ##1
        (ramp_cfg.random_spread_enable == $past(reg_wdata[1], 2)) &&
        (ramp_cfg.triangle_enable == $past(reg_wdata[0], 2)) &&
        (ramp_cfg.manual == $past(reg_wdata[4], 2));
  endproperty
  a_spread_en: assert property (p_spread_en) // RULE_06 RULE_08 RULE_09
    else $error("spread enables not applied");

  property p_manual_fields;
    @(posedge mclk) disable iff (srst)
      manual |=> (ramp_cfg.triangle_fall_step == $past(steps_reg[7:4])) &&
                 (ramp_cfg.triangle_rise_step == $past(steps_reg[3:0])) &&
                 (ramp_cfg.ramp_amplitude_setting == $past(ampbnd_reg[6:5])) &&
                 (ramp_cfg.triangle_period_limit == $past(ampbnd_reg[4:0])) &&
                 (ramp_cfg.pre_div2 == $past(enable_reg[5]));
  endproperty
  a_manual_fields: assert property (p_manual_fields) // RULE_07 RULE_11 RULE_12 RULE_13 RULE_14
    else $error("manual fields not applied");

  property p_fault_read;
    @(posedge mclk) disable iff (srst)
      (reg_rd && hit_fault) |=> reg_rdata[3:0] == $past(fault_word);
  endproperty
  a_fault_read: assert property (p_fault_read) // RULE_15
    else $error("fault bits misread");

  property p_fault_hold;
    @(posedge mclk) disable iff (srst)
      (fsync2 != fsync3) |=> $stable(fault_now);
  endproperty
  a_fault_hold: assert property (p_fault_hold) // RULE_15 RULE_16
    else $error("fault bits taken before stages agreed");

  property p_fault_take;
    @(posedge mclk) disable iff (srst)
      (fsync2 == fsync3) |=> fault_now == $past(fsync3);
  endproperty
  a_fault_take: assert property (p_fault_take) // RULE_15 RULE_16
    else $error("agreed fault bits not taken");

  property p_reset_values;
    @(posedge mclk)
      srst |=> (freq_reg == rsscp_pkg::RST_FREQ) &&
               (steps_reg == rsscp_pkg::RST_STEPS) &&
               (ampbnd_reg == rsscp_pkg::RST_AMPBND) &&
               (enable_reg == rsscp_pkg::RST_ENABLE) &&
               !reg_rvalid && (ramp_cfg == '0);
  endproperty
  a_reset_values: assert property (p_reset_values) // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
    else $error("reset values wrong");

  property p_range_fields;
    @(posedge mclk) disable iff (srst)
      (reg_wr && hit_range) |=> ##1
        (ramp_cfg.random_spread_range == $past(reg_wdata[6:4], 2)) &&
        (ramp_cfg.triangle_ctrl == $past(reg_wdata[3:0], 2));
  endproperty
  a_range_fields: assert property (p_range_fields) // RULE_08 RULE_09
    else $error("spread range fields not applied");

  property p_auto_steps;
    @(posedge mclk) disable iff (srst)
      (!srst && !manual) |=> (ramp_cfg.triangle_fall_step == rsscp_pkg::AUTO_STEP) &&
                  (ramp_cfg.triangle_rise_step == rsscp_pkg::AUTO_STEP) &&
                  (ramp_cfg.ramp_amplitude_setting == rsscp_pkg::AUTO_AMP) &&
                  (ramp_cfg.triangle_period_limit == rsscp_pkg::AUTO_BOUND);
  endproperty
  a_auto_steps: assert property (p_auto_steps) // RULE_17
    else $error("manual step fields used outside manual mode");

  property p_fault_ro_rest;
    @(posedge mclk) disable iff (srst)
      (reg_wr && hit_fault) |=> $stable(range_reg) && $stable(freq_reg) &&
                                $stable(steps_reg) && $stable(ampbnd_reg);
  endproperty
  a_fault_ro_rest: assert property (p_fault_ro_rest) // RULE_18
    else $error("fault write disturbed spread registers");

  property p_phase_hold;
    @(posedge mclk) disable iff (srst)
      !(reg_wr && hit_phase) |=> $stable(phase_reg);
  endproperty
  a_phase_hold: assert property (p_phase_hold) // RULE_01
    else $error("phase control changed without a write");

  property p_freq_read;
    @(posedge mclk) disable iff (srst)
      (reg_rd && hit_freq) |=> reg_rvalid && (reg_rdata == $past(freq_reg));
  endproperty
  a_freq_read: assert property (p_freq_read) // RULE_10
    else $error("divisor read back wrong");

  property p_steps_read;
    @(posedge mclk) disable iff (srst)
      (reg_rd && hit_steps) |=> reg_rvalid && (reg_rdata == $past(steps_reg));
  endproperty
  a_steps_read: assert property (p_steps_read) // RULE_11 RULE_12
    else $error("step fields read back wrong");

  property p_ampbnd_read;
    @(posedge mclk) disable iff (srst)
      (reg_rd && hit_ampbnd) |=> reg_rvalid && (reg_rdata == $past(ampbnd_reg));
  endproperty
  a_ampbnd_read: assert property (p_ampbnd_read) // RULE_13 RULE_14
    else $error("amplitude and limit read back wrong");

endmodule : rsscp_ctrl

`default_nettype wire

// file: tb/rsscp_host.sv
`timescale 1ns/10ps
`default_nettype none

// host on the register port: one-cycle strobes, released lines toggled
module rsscp_host (
  input  wire logic       mclk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    for (i = 0; i < 4 && !ok; i++) begin
      if (i > 0)
        @(posedge mclk);
      #1;
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end
    end
  endtask : rd
endmodule : rsscp_host

`default_nettype wire

// file: tb/rsscp_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none

module rsscp_ctrl_bench;
  localparam logic [7:0] MSK [6] = '{8'h0f, 8'h33, 8'h7f, 8'hff, 8'hff, 8'h7f};
  localparam logic [7:0] RSTV [6] = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24};
  logic                        mclk;
  logic                        srst;
  wire logic                   reg_wr;
  wire logic                   reg_rd;
  wire logic [7:0]             reg_addr;
  wire logic [7:0]             reg_wdata;
  wire logic [7:0]             reg_rdata;
  wire logic                   reg_rvalid;
  rsscp_pkg::rsscp_fault_t     fault_pins;
  rsscp_pkg::rsscp_ramp_cfg_t  ramp_cfg;
  logic [7:0]                  sh [6];
  int                          n_fail;
  int                          compares;

  rsscp_ctrl u_dut (.mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fault_pins(fault_pins), .ramp_cfg(ramp_cfg));
  rsscp_host u_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic rsscp_pkg::rsscp_ramp_cfg_t model_cfg();
    rsscp_pkg::rsscp_ramp_cfg_t c;
    logic                       man;
    man                      = sh[1][4];
    c.phase_sel              = sh[0][3:2];
    c.audio_sync             = sh[0][1];
    c.phase_sync             = sh[0][0];
    c.manual                 = man;
    c.pre_div2               = man & sh[1][5];
    c.random_spread_enable   = sh[1][1];
    c.triangle_enable        = sh[1][0];
    c.random_spread_range    = sh[2][6:4];
    c.triangle_ctrl          = sh[2][3:0];
    c.manual_ramp_divisor    = man ? sh[3] : 8'h50;
    c.triangle_fall_step     = man ? sh[4][7:4] : 4'h1;
    c.triangle_rise_step     = man ? sh[4][3:0] : 4'h1;
    c.ramp_amplitude_setting = man ? sh[5][6:5] : 2'h1;
    c.triangle_period_limit  = man ? sh[5][4:0] : 5'h04;
    return c;
  endfunction : model_cfg

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic       ok;
    u_host.rd(a, d, ok);
    check({what, " rvalid"}, 40'(ok), 40'h1);
    if (ok)
      check(what, 40'(d), 40'(exp));
    else
      give_verdict();
  endtask : rchk

  // write, mirror masked value, then compare config and read back
  task automatic wsh(input logic [7:0] a, input logic [7:0] d, input string what);
    int k;
    k = int'(a - 8'h6a);
    u_host.wr(a, d);
    sh[k] = d & MSK[k];
    repeat (2) @(posedge mclk);
    #1;
    check({what, " cfg"}, 40'(ramp_cfg), 40'(model_cfg()));
    rchk(a, sh[k], what);
  endtask : wsh

  task automatic test_reset();
    int i;
    check("reset cfg", 40'(ramp_cfg), 40'(model_cfg()));
    for (i = 0; i < 6; i++)
      rchk(8'h6a + 8'(i), RSTV[i], "reset value");
    $display("test_reset done");
  endtask : test_reset

  // phase set first, before anything that resembles playing
  task automatic test_phase();
    int p;
    for (p = 3; p >= 0; p--)
      wsh(8'h6a, {4'hf, 2'(p), 1'(p >> 1), 1'(p)}, "phase");
    wsh(8'h6a, 8'h00, "phase clear");
    $display("test_phase done");
  endtask : test_phase

  // same spread settings a multi-device host would use everywhere
  task automatic test_manual();
    wsh(8'h6c, 8'hff, "range");
    wsh(8'h6d, 8'h01, "divisor");
    wsh(8'h6e, 8'h9c, "steps");
    wsh(8'h6f, 8'hff, "amp bound");
    wsh(8'h6b, 8'hef, "auto mode");
    wsh(8'h6b, 8'h30, "manual div");
    wsh(8'h6b, 8'h12, "manual nodiv");
    wsh(8'h6f, 8'h4b, "amp bound2");
    $display("test_manual done");
  endtask : test_manual

  task automatic test_fault();
    logic [3:0] pat [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    int         i;
    for (i = 0; i < 5; i++) begin
      @(posedge mclk);
      fault_pins <= pat[i];
      repeat (6) @(posedge mclk);
      rchk(8'h70, {4'h0, pat[i]}, "fault");
    end
    // one-cycle dip on the pins must not reach the register
    @(posedge mclk);
    fault_pins <= 4'h0;
    @(posedge mclk);
    fault_pins <= 4'hf;
    rchk(8'h70, 8'h0f, "fault glitch a");
    rchk(8'h70, 8'h0f, "fault glitch b");
    u_host.wr(8'h70, 8'hff);
    rchk(8'h70, 8'h0f, "fault after write");
    rchk(8'h7f, 8'h00, "unmapped");
    check("cfg after fault write", 40'(ramp_cfg), 40'(model_cfg()));
    $display("test_fault done");
  endtask : test_fault

  // reset again in mid-run, faults still present at the pins
  task automatic test_mid_reset();
    int i;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (i = 0; i < 6; i++)
      sh[i] = RSTV[i];
    repeat (2) @(posedge mclk);
    #1;
    check("mid reset cfg", 40'(ramp_cfg), 40'(model_cfg()));
    rchk(8'h6b, 8'h00, "mid reset enable");
    rchk(8'h6d, 8'h50, "mid reset divisor");
    rchk(8'h70, 8'h0f, "mid reset fault");
    $display("test_mid_reset done");
  endtask : test_mid_reset

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail     = 0;
    compares   = 0;
    srst       = 1'b1;
    fault_pins = '0;
    for (int i = 0; i < 6; i++)
      sh[i] = RSTV[i];
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    test_reset();
    test_phase();
    test_manual();
    test_fault();
    test_mid_reset();
    give_verdict();
  end
endmodule : rsscp_ctrl_bench

`default_nettype wire
